// ---- design/status_pkg.sv ----
package status_pkg;
    // ****
    // command codes of the status registers
    // ****
    localparam logic [7:0] cmd_clear_faults   = 8'h03; // fault clear
    localparam logic [7:0] cmd_page           = 8'h00; // page select
    localparam logic [7:0] cmd_temperature    = 8'h7d; // temperature status
    localparam logic [7:0] cmd_cml            = 8'h7e; // comm/mem/logic
    localparam logic [7:0] cmd_vendor_flags   = 8'h80; // vendor flags
    localparam logic [7:0] cmd_pad_snapshot   = 8'he5; // pad snapshot word
    localparam logic [7:0] cmd_common_status  = 8'hef; // common status
    localparam logic [7:0] page_all           = 8'hff; // global page value
    // ****
    // field positions
    // ****
    localparam int temp_ot_fault_bit  = 7; // over-temp fault
    localparam int temp_ut_fault_bit  = 4; // under-temp fault
    localparam int cml_cmd_bit        = 7; // bad command
    localparam int cml_data_bit       = 6; // bad data
    localparam int cml_pec_bit        = 5; // pec fault
    localparam int cml_mem_bit        = 4; // memory fault
    localparam int cml_bus_bit        = 1; // other bus fault
    localparam int vf_discharge_bit   = 7; // discharge fault
    localparam int vf_fault1_bit      = 6; // fault line one
    localparam int vf_fault0_bit      = 5; // fault line zero
    localparam int vf_servo_bit       = 4; // servo target reached
    localparam int vf_dac_conn_bit    = 3; // dac connected
    localparam int vf_dac_sat_bit     = 2; // dac saturated
    localparam int vf_aux_bit         = 1; // aux fault released
    localparam int vf_watchdog_bit    = 0; // watchdog fault
    // alerting vendor flags (7,6,5,0)
    localparam logic [7:0] vf_alert_mask  = 8'he1;
    // sticky per-channel vendor flags (7,6,5,2)
    localparam logic [7:0] vf_sticky_mask = 8'he4;
    localparam logic [3:0] common_ones    = 4'hf; // bits 5:2 of common
    localparam logic [1:0] asel_high      = 2'h3; // pin high
    localparam logic [1:0] asel_float     = 2'h2; // pin floating
    localparam logic [1:0] asel_low       = 2'h0; // pin low
    localparam logic [1:0] pad_reserved   = 2'h0; // bits 11:10
    localparam int         num_channels   = 4; // channel count
    // address-select pin sense state
    typedef enum logic [1:0] {
        sense_low   = 2'b00,
        sense_float = 2'b01,
        sense_high  = 2'b10
    } asel_sense_t;
endpackage

// ---- design/channel_flags.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****
// per-channel sticky temperature and vendor flags
// ****
module channel_flags
    import status_pkg::*;
(
    input  wire logic       clock,           // system clock
    input  wire logic       resetn,          // async reset, low
    input  wire logic       clear,           // fault clear for channel
    input  wire logic       turn_on,         // channel commanded on
    input  wire logic [3:0] temp_event,      // ot_f, ot_w, ut_w, ut_f
    input  wire logic       discharge_event, // discharge fault
    input  wire logic       fault1_event,    // fault line one response
    input  wire logic       fault0_event,    // fault line zero response
    input  wire logic       dac_sat_event,   // servo ended saturated
    output logic      [3:0] temp_flags,      // sticky temperature bits
    output logic      [7:0] vendor_sticky    // sticky vendor bits
);
    // state of one channel
    typedef struct packed {
        logic [3:0] temp; // temperature bits 7:4
        logic [7:0] vf;   // vendor sticky bits
    } chan_state_t;

    chan_state_t state;      // registered state
    chan_state_t next_state; // next state
    logic [7:0]  set_vf;     // vendor set pulses

    // ****
    // next state: set beats clear
    // ****
    always_comb begin
        set_vf = 8'h00;
        set_vf[vf_discharge_bit] = discharge_event;
        set_vf[vf_fault1_bit]    = fault1_event;
        set_vf[vf_fault0_bit]    = fault0_event;
        set_vf[vf_dac_sat_bit]   = dac_sat_event;
        next_state = state;
        // temperature flags clear only by fault clear
        if (clear) begin
            next_state.temp = 4'h0;
        end
        next_state.temp = next_state.temp | temp_event;
        // vendor sticky flags clear on fault clear or turn on
        if (clear || turn_on) begin
            next_state.vf = 8'h00;
        end
        next_state.vf = (next_state.vf | set_vf) & vf_sticky_mask;
    end

    // ****
    // state register
    // ****
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign temp_flags    = state.temp;
    assign vendor_sticky = state.vf;
endmodule
`default_nettype wire

// ---- design/status_pad_registers.sv ----
`timescale 1ns/10ps
`default_nettype none
module status_pad_registers
    import status_pkg::*;
#(
    parameter int channels = num_channels // channel count
)(
    input  wire logic        clock,           // 125 MHz clock
    input  wire logic        resetn,          // async reset, low
    input  wire logic        cmd_valid,       // command byte pulse
    input  wire logic  [7:0] cmd_code,        // command code
    input  wire logic        cmd_read,        // read transaction
    input  wire logic        write_valid,     // write data pulse
    input  wire logic  [7:0] write_data,      // write data byte
    output logic             cmd_ack,         // command accepted
    output logic             cmd_nack,        // command refused
    output logic      [15:0] read_data,       // registered read data
    output logic             read_valid,      // read data pulse
    input  wire logic        bad_data_event,  // illegal data
    input  wire logic        pec_extra_event, // extra non-pec byte
    input  wire logic        malformed_event, // malformed transaction
    input  wire logic        memory_fault,    // nonvolatile fault
    input  wire logic        engine_busy,     // memory or other op busy
    input  wire logic  [3:0] temp_event   [channels], // temp events
    input  wire logic  [channels-1:0] discharge_event, // discharge
    input  wire logic  [channels-1:0] fault1_event,    // line one
    input  wire logic  [channels-1:0] fault0_event,    // line zero
    input  wire logic  [channels-1:0] dac_sat_event,   // saturation
    input  wire logic  [channels-1:0] servo_reached,   // live servo
    input  wire logic  [channels-1:0] dac_connected,   // live dac
    input  wire logic  [channels-1:0] turn_on,         // commanded on
    input  wire logic        aux_released,    // aux fault released
    input  wire logic        watchdog_expired,// watchdog pulse
    input  wire logic        pwrgd_drive_low, // own power-good drive
    input  wire logic        fault_zero_drive,// own fault line 0 drive
    input  wire logic        fault_one_drive, // own fault line 1 drive
    input  wire logic        shared_fault_line_zero_n, // line 0 level
    input  wire logic        shared_fault_line_one_n,  // line 1 level
    input  wire status_pkg::asel_sense_t addr_select_pin_zero, // asel 0
    input  wire status_pkg::asel_sense_t addr_select_pin_one,  // asel 1
    input  wire logic        run_pin_zero,    // run pin 0
    input  wire logic        run_pin_one,     // run pin 1
    input  wire logic        run_pin_two,     // run pin 2
    input  wire logic        run_pin_three,   // run pin 3
    input  wire logic        alert_line_n,    // wired alert level
    input  wire logic        share_clk_low,   // clock-share held low
    input  wire logic        write_protect,   // write-protect level
    output logic             alert_drive_n,   // own alert drive, low
    output logic             busy_flag        // busy sticky to summary
);
    // ****
    // state
    // ****
    typedef struct packed {
        logic [7:0]  page;      // selected page
        logic [7:0]  cml;       // comm/mem/logic flags
        logic        watchdog;  // global sticky watchdog
        logic        busy;      // busy seen flag
        logic        page_wait; // page write pending
        logic [15:0] rdata;     // read data
        logic        rvalid;    // read pulse
        logic        ack;       // ack pulse
        logic        nack;      // nack pulse
    } reg_state_t;

    reg_state_t state;      // registered state
    reg_state_t next_state; // next state

    logic [channels-1:0] chan_clear;   // fault clear per channel
    logic [3:0]          temp_flags [channels]; // sticky temperature
    logic [7:0]          vf_sticky  [channels]; // sticky vendor bits
    logic                do_clear;     // fault clear taken
    logic                any_alert;    // any alerting flag set
    logic [7:0]          vf_read;      // vendor byte for page
    logic [7:0]          temp_read;    // temperature byte for page
    logic [15:0]         pad_word;     // pad snapshot
    logic [7:0]          common_byte;  // common status byte
    logic [1:0]          page_idx;     // page as index
    logic                page_ok;      // page selects a channel
    logic                known_cmd;    // command supported

    // ****
    // per-channel flags
    // ****
    genvar g;
    generate
        for (g = 0; g < channels; g++) begin : gen_chan
            channel_flags u_flags (
                .clock           (clock),
                .resetn          (resetn),
                .clear           (chan_clear[g]),
                .turn_on         (turn_on[g]),
                .temp_event      (temp_event[g]),
                .discharge_event (discharge_event[g]),
                .fault1_event    (fault1_event[g]),
                .fault0_event    (fault0_event[g]),
                .dac_sat_event   (dac_sat_event[g]),
                .temp_flags      (temp_flags[g]),
                .vendor_sticky   (vf_sticky[g])
            );
        end
    endgenerate

    // ****
    // decode and read muxes
    // ****
    always_comb begin
        page_idx  = state.page[1:0];
        page_ok   = (state.page < 8'(channels));
        known_cmd = (cmd_code == cmd_clear_faults) ||
                    (cmd_code == cmd_page) ||
                    (cmd_code == cmd_temperature) ||
                    (cmd_code == cmd_cml) ||
                    (cmd_code == cmd_vendor_flags) ||
                    (cmd_code == cmd_pad_snapshot) ||
                    (cmd_code == cmd_common_status);
        do_clear  = cmd_valid && !engine_busy && !cmd_read &&
                    (cmd_code == cmd_clear_faults);
        // clear one page or all pages
        for (int i = 0; i < channels; i++) begin
            chan_clear[i] = do_clear && ((state.page == page_all) ||
                            (state.page == 8'(i)));
        end
        // temperature byte, low nibble zero
        temp_read = page_ok ? {temp_flags[page_idx], 4'h0} : 8'h00;
        // vendor byte: paged 7:2, global 1:0
        vf_read = 8'h00;
        if (page_ok) begin
            vf_read = vf_sticky[page_idx];
            vf_read[vf_servo_bit]    = servo_reached[page_idx];
            vf_read[vf_dac_conn_bit] = dac_connected[page_idx];
        end
        vf_read[vf_aux_bit]      = aux_released;
        vf_read[vf_watchdog_bit] = state.watchdog;
        // alert from alerting flags of any channel
        any_alert = state.watchdog;
        for (int i = 0; i < channels; i++) begin
            any_alert = any_alert |
                        (|(vf_sticky[i] & vf_alert_mask));
        end
        // raw pad levels, no filtering
        pad_word = {!pwrgd_drive_low, alert_drive_n,
                    !fault_zero_drive, !fault_one_drive,
                    pad_reserved,
                    asel_code(addr_select_pin_one),
                    asel_code(addr_select_pin_zero),
                    run_pin_one, run_pin_zero,
                    shared_fault_line_zero_n,
                    shared_fault_line_one_n,
                    run_pin_two, run_pin_three};
        common_byte = {alert_line_n, !engine_busy, common_ones,
                       share_clk_low, write_protect};
    end

    // address-select pin to field code
    function automatic logic [1:0] asel_code(input asel_sense_t s);
        logic [1:0] c;
        c = asel_low;
        unique case (s)
            sense_high:  c = asel_high;
            sense_float: c = asel_float;
            sense_low:   c = asel_low;
            default:     c = asel_low; // unused code
        endcase
        return c;
    endfunction

    // ****
    // next state
    // ****
    always_comb begin
        next_state        = state;
        next_state.rvalid = 1'b0;
        next_state.ack    = 1'b0;
        next_state.nack   = 1'b0;
        // fault clear first, events after so set wins
        if (do_clear) begin
            next_state.cml      = 8'h00;
            next_state.watchdog = 1'b0;
            next_state.busy     = 1'b0;
        end
        if (cmd_valid) begin
            if (engine_busy && cmd_code != cmd_common_status) begin
                next_state.nack = 1'b1;
                next_state.busy = 1'b1;
            end else if (!known_cmd) begin
                next_state.nack = 1'b1;
                next_state.cml[cml_cmd_bit] = 1'b1;
            end else begin
                next_state.ack = 1'b1;
                if (cmd_read) begin
                    next_state.rvalid = 1'b1;
                    unique case (cmd_code)
                        cmd_temperature:   next_state.rdata = 16'(temp_read);
                        cmd_cml:           next_state.rdata = 16'(state.cml);
                        cmd_vendor_flags:  next_state.rdata = 16'(vf_read);
                        cmd_pad_snapshot:  next_state.rdata = pad_word;
                        cmd_common_status: next_state.rdata = 16'(common_byte);
                        cmd_page:          next_state.rdata = 16'(state.page);
                        default:           next_state.rdata = 16'h0000;
                    endcase
                end else if (cmd_code == cmd_page) begin
                    next_state.page_wait = 1'b1;
                end else if (cmd_code != cmd_clear_faults) begin
                    next_state.cml[cml_data_bit] = 1'b1;
                end
            end
        end
        // page write data; beyond range is bad data
        if (write_valid && state.page_wait) begin
            next_state.page_wait = 1'b0;
            if (write_data < 8'(channels) || write_data == page_all) begin
                next_state.page = write_data;
            end else begin
                next_state.cml[cml_data_bit] = 1'b1;
            end
        end
        if (bad_data_event)   next_state.cml[cml_data_bit] = 1'b1;
        if (pec_extra_event)  next_state.cml[cml_pec_bit]  = 1'b1;
        if (memory_fault)     next_state.cml[cml_mem_bit]  = 1'b1;
        if (malformed_event)  next_state.cml[cml_bus_bit]  = 1'b1;
        if (watchdog_expired) next_state.watchdog = 1'b1;
        next_state.cml[3:2] = 2'b00;
        next_state.cml[0]   = 1'b0;
    end

    // ****
    // state register
    // ****
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ****
    // outputs
    // ****
    assign cmd_ack       = state.ack;
    assign cmd_nack      = state.nack;
    assign read_data     = state.rdata;
    assign read_valid    = state.rvalid;
    assign alert_drive_n = !(any_alert || (|state.cml));
    assign busy_flag     = state.busy;
endmodule
`default_nettype wire

// ---- test/pmbus_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****
// host side: sends command bytes, collects the answers
// ****
module pmbus_host_model
    import status_pkg::*;
(
    input  wire logic        clock,       // system clock
    input  wire logic        cmd_ack,     // command accepted
    input  wire logic        cmd_nack,    // command refused
    input  wire logic        read_valid,  // read strobe
    input  wire logic [15:0] read_data,   // read word
    output logic             cmd_valid,   // command pulse
    output logic       [7:0] cmd_code,    // command code
    output logic             cmd_read,    // read flag
    output logic             write_valid, // data pulse
    output logic       [7:0] write_data   // data byte
);
    // idle bus at time zero
    initial begin
        {cmd_valid, cmd_read, write_valid} = 3'h0;
        {cmd_code, write_data} = 16'h0000;
    end
    // one command byte; answer is {ack, nack, read strobe}
    task automatic xfer(input logic [7:0] code, input logic rd,
                        output logic [2:0] ans, output logic [15:0] d);
        @(posedge clock);
        #1 cmd_valid = 1'b1;
        cmd_code = code;
        cmd_read = rd;
        @(posedge clock);
        #1 cmd_valid = 1'b0;
        cmd_code = ~code; // stale code would hide a missed strobe
        ans = {cmd_ack, cmd_nack, read_valid};
        d = read_data;
    endtask
    // one data byte after a write command
    task automatic put(input logic [7:0] d);
        @(posedge clock);
        #1 write_valid = 1'b1;
        write_data = d;
        @(posedge clock);
        #1 write_valid = 1'b0;
        write_data = ~d;
    endtask
    // wait for not-busy through the common status byte
    task automatic poll(output logic ok);
        logic [2:0]  a;
        logic [15:0] d;
        ok = 1'b0;
        for (int i = 0; i < 64 && !ok; i++) begin
            xfer(cmd_common_status, 1'b1, a, d);
            ok = d[6];
        end
    endtask
endmodule
`default_nettype wire

// ---- test/status_pad_registers_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****
// port checks of the status registers
// ****
module status_pad_registers_sva
    import status_pkg::*;
#(
    parameter int channels = num_channels // channel count
)(
    input wire logic                clock,         // clock
    input wire logic                resetn,        // reset, low
    input wire logic                cmd_valid,     // command pulse
    input wire logic          [7:0] cmd_code,      // command code
    input wire logic                cmd_read,      // read flag
    input wire logic                cmd_ack,       // accepted
    input wire logic                cmd_nack,      // refused
    input wire logic         [15:0] read_data,     // read word
    input wire logic                read_valid,    // read strobe
    input wire logic                engine_busy,   // busy level
    input wire logic                watchdog_expired, // watchdog
    input wire logic [channels-1:0] turn_on,       // commanded on
    input wire logic                run_pin_zero,  // run pin 0
    input wire logic                run_pin_one,   // run pin 1
    input wire logic                run_pin_two,   // run pin 2
    input wire logic                run_pin_three, // run pin 3
    input wire logic                alert_line_n,  // alert level
    input wire logic                share_clk_low, // clock share
    input wire logic                write_protect, // protect pin
    input wire logic                alert_drive_n, // own alert
    input wire logic                busy_flag      // busy seen
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!resetn);
    // refused while busy, and plain reads
    wire logic busy_cmd = cmd_valid && engine_busy
                          && cmd_code != cmd_common_status;
    wire logic rd_cmd   = cmd_valid && cmd_read && !engine_busy;
    AST_ANSWER_ONCE: assert property (
        cmd_valid |=> cmd_ack != cmd_nack)
        else $error("not exactly one answer");
    AST_BUSY_REFUSE: assert property (
        busy_cmd |=> cmd_nack ##[0:1] busy_flag)
        else $error("busy command not refused");
    AST_TEMP_LOW: assert property (
        rd_cmd && cmd_code == cmd_temperature
        |=> read_valid && read_data[3:0] == 4'h0)
        else $error("temperature low bits set");
    AST_CML_ZERO: assert property (
        rd_cmd && cmd_code == cmd_cml
        |=> read_valid && read_data[3:2] == 2'h0 && !read_data[0])
        else $error("cml unused bits set");
    AST_PAD_RUN: assert property (
        rd_cmd && cmd_code == cmd_pad_snapshot |=> read_valid
        && read_data[11:10] == 2'h0
        && read_data[5:4] == {$past(run_pin_one), $past(run_pin_zero)}
        && read_data[1:0] == {$past(run_pin_two), $past(run_pin_three)})
        else $error("pad run bits wrong");
    AST_PAD_ALERT: assert property (
        rd_cmd && cmd_code == cmd_pad_snapshot
        |=> read_data[14] == $past(alert_drive_n))
        else $error("pad alert bit wrong");
    AST_COMMON: assert property (
        cmd_valid && cmd_read && cmd_code == cmd_common_status
        |=> cmd_ack && read_data[7:0] == {$past(alert_line_n),
        !$past(engine_busy), common_ones, $past(share_clk_low),
        $past(write_protect)})
        else $error("common byte wrong");
    AST_WD_ALERT: assert property (
        watchdog_expired |=> !alert_drive_n)
        else $error("watchdog did not alert");
    AST_ALERT_HOLD: assert property (
        !alert_drive_n && !cmd_valid && turn_on == '0 |=> !alert_drive_n)
        else $error("alert dropped without clear");
    COV_BUSY: cover property (busy_cmd ##1 cmd_nack);
    COV_WD: cover property (watchdog_expired ##1 !alert_drive_n);
    COV_PAD: cover property (rd_cmd && cmd_code == cmd_pad_snapshot);
endmodule
bind status_pad_registers status_pad_registers_sva #(.channels(channels))
    status_pad_registers_sva_i (.*);
`default_nettype wire

// ---- test/tb_status_pad_registers.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_status_pad_registers
    import status_pkg::*;
;
    // ****
    // signals
    // ****
    logic        clock, resetn, cmd_valid, cmd_read, write_valid;
    logic  [7:0] cmd_code, write_data;
    logic        cmd_ack, cmd_nack, read_valid, alert_drive_n, busy_flag;
    logic [15:0] read_data, dat;
    logic        bad_data_event, pec_extra_event, malformed_event;
    logic        memory_fault, engine_busy, aux_released, watchdog_expired;
    logic  [3:0] temp_event [4];
    logic  [3:0] discharge_event, fault1_event, fault0_event, dac_sat_event;
    logic  [3:0] servo_reached, dac_connected, turn_on;
    logic        pwrgd_drive_low, fault_zero_drive, fault_one_drive;
    logic        shared_fault_line_zero_n, shared_fault_line_one_n;
    asel_sense_t addr_select_pin_zero, addr_select_pin_one;
    logic        run_pin_zero, run_pin_one, run_pin_two, run_pin_three;
    logic        alert_line_n, share_clk_low, write_protect, ok;
    logic  [2:0] ans;
    int          err_total, check_count;
    status_pad_registers #(.channels(4)) status_pad_registers_i (.*);
    pmbus_host_model pmbus_host_model_i (.*);
    // ****
    // helpers
    // ****
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge clock);
        #1;
    endtask
    task automatic cmd(input logic [7:0] c, input logic rd);
        pmbus_host_model_i.xfer(c, rd, ans, dat);
    endtask
    // read with ack and strobe expected
    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        cmd(c, 1'b1);
        chk({13'h0, ans}, 16'h5);
        chk(dat, exp);
    endtask
    task automatic page(input logic [7:0] p);
        cmd(cmd_page, 1'b0);
        pmbus_host_model_i.put(p);
    endtask
    task automatic print_verdict();
        if (err_total == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ****
    // scenarios
    // ****
    task automatic s_cml();
        rd(cmd_cml, 16'h0);
        cmd(8'h55, 1'b0);
        chk({13'h0, ans}, 16'h2);
        cmd(cmd_cml, 1'b0);
        chk({13'h0, ans}, 16'h4);
        {pec_extra_event, malformed_event, memory_fault} = 3'h7;
        tick();
        {pec_extra_event, malformed_event, memory_fault} = 3'h0;
        rd(cmd_cml, 16'hf2);
        cmd(cmd_clear_faults, 1'b0);
        rd(cmd_cml, 16'h0);
    endtask
    task automatic s_flags();
        page(8'h02);
        temp_event[2] = 4'hf;
        {discharge_event, fault1_event, fault0_event} = {3{4'h4}};
        {dac_sat_event, servo_reached, dac_connected} = {3{4'h4}};
        {aux_released, watchdog_expired, bad_data_event} = 3'h7;
        tick();
        temp_event[2] = 4'h0;
        {discharge_event, fault1_event, fault0_event, dac_sat_event} = '0;
        {watchdog_expired, bad_data_event} = '0;
        rd(cmd_temperature, 16'hf0);
        rd(cmd_vendor_flags, 16'hff);
        rd(cmd_cml, 16'h40);
        page(8'h01);
        rd(cmd_temperature, 16'h0);
        rd(cmd_vendor_flags, 16'h03);
        turn_on = 4'h4;
        tick();
        turn_on = 4'h0;
        page(8'h02);
        rd(cmd_vendor_flags, 16'h1b);
        chk({15'h0, alert_drive_n}, 16'h0);
        {servo_reached, dac_connected} = '0;
        aux_released = 1'b0;
        rd(cmd_vendor_flags, 16'h01);
        cmd(cmd_clear_faults, 1'b0);
        rd(cmd_vendor_flags, 16'h0);
        chk({15'h0, alert_drive_n}, 16'h1);
    endtask
    task automatic s_global();
        dac_sat_event = 4'h1;
        tick();
        dac_sat_event = 4'h0;
        chk({15'h0, alert_drive_n}, 16'h1);
        page(8'h00);
        rd(cmd_vendor_flags, 16'h04);
        temp_event[3] = 4'h8;
        tick();
        temp_event[3] = 4'h0;
        page(page_all);
        cmd(cmd_clear_faults, 1'b0);
        page(8'h03);
        rd(cmd_temperature, 16'h0);
        rd(cmd_vendor_flags, 16'h0);
    endtask
    task automatic s_pads();
        logic [1:0] enc [3] = '{asel_low, asel_float, asel_high};
        for (int i = 0; i < 3; i++) begin
            addr_select_pin_zero = asel_sense_t'(i);
            addr_select_pin_one = asel_sense_t'(2 - i);
            {run_pin_one, run_pin_zero, run_pin_two, run_pin_three} =
                4'(4'h5 << i);
            {shared_fault_line_zero_n, shared_fault_line_one_n} = 2'(i);
            {pwrgd_drive_low, fault_zero_drive, fault_one_drive} = 3'(i + 3);
            tick();
            rd(cmd_pad_snapshot, {~pwrgd_drive_low, 1'b1, ~fault_zero_drive,
               ~fault_one_drive, 2'h0, enc[2 - i], enc[i], run_pin_one,
               run_pin_zero, shared_fault_line_zero_n, shared_fault_line_one_n,
               run_pin_two, run_pin_three});
        end
    endtask
    task automatic s_busy();
        {alert_line_n, share_clk_low, write_protect} = 3'h3;
        engine_busy = 1'b1;
        cmd(cmd_common_status, 1'b1);
        chk({13'h0, ans}, 16'h5);
        chk(dat, 16'h3f);
        cmd(cmd_cml, 1'b1);
        chk({13'h0, ans}, 16'h2);
        chk({14'h0, busy_flag, alert_drive_n}, 16'h3);
        engine_busy = 1'b0;
        pmbus_host_model_i.poll(ok);
        chk({15'h0, ok}, 16'h1);
    endtask
    // ****
    // clock, reset and sequence
    // ****
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        {err_total, check_count} = '0;
        resetn = 1'b0;
        {bad_data_event, pec_extra_event, malformed_event} = '0;
        {memory_fault, engine_busy, aux_released, watchdog_expired} = '0;
        temp_event = '{default: 4'h0};
        {discharge_event, fault1_event, fault0_event, dac_sat_event} = '0;
        {servo_reached, dac_connected, turn_on} = '0;
        {pwrgd_drive_low, fault_zero_drive, fault_one_drive} = '0;
        {shared_fault_line_zero_n, shared_fault_line_one_n} = 2'h3;
        {addr_select_pin_zero, addr_select_pin_one} = {sense_low, sense_low};
        {run_pin_zero, run_pin_one, run_pin_two, run_pin_three} = '0;
        {alert_line_n, share_clk_low, write_protect} = 3'h4;
        repeat (6) @(posedge clock);
        #1 resetn = 1'b1;
        s_cml();
        s_flags();
        s_global();
        s_pads();
        s_busy();
        print_verdict();
    end
endmodule
`default_nettype wire
